/* File: logic/vsbd_pkg.sv */
// Shared constants and types of the serial byte decoder
`default_nettype none
package vsbd_pkg;
  // Serial byte and buffer geometry
  localparam int BYTE_W = 8;
  localparam int CNT_BITS = 3;
  localparam int PTR_W = 4;
  localparam int POS_N = 16;
  localparam int CODE_W = 6;
  localparam int LUM_W = 5;
  localparam int DIG_W = 5;
  localparam int FIFO_DEPTH = 2;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Control byte prefixes
  localparam logic [3:0] OP_POINTER = 4'ha;
  localparam logic [3:0] OP_DIGITS = 4'hc;
  localparam logic [2:0] OP_LUMA = 3'h7;

  // Reset values
  localparam logic [PTR_W-1:0] PTR_RST = 4'hf;
  localparam logic [DIG_W-1:0] DIGITS_RST = 5'h10;
  localparam logic [LUM_W-1:0] LUM_RST = 5'h00;
  localparam logic [LUM_W-1:0] LUM_FULL = 5'h1f;

  // Codes that attach to the previous character
  localparam logic [CODE_W-1:0] CODE_DOT = 6'h2e;
  localparam logic [CODE_W-1:0] CODE_COMMA = 6'h2c;

  // Register map, byte addresses
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_FLAGS = 8'h08;
  localparam logic [1:0] CHAR_PAGE = 2'h1;
  localparam int CTRL_HOLD_BIT = 0;
  localparam int FLAG_OVR_BIT = 0;
  localparam int STAT_PTR_LSB = 0;
  localparam int STAT_DIG_LSB = 8;
  localparam int STAT_LUM_LSB = 16;
  localparam int STAT_LVL_LSB = 24;
  localparam int CHAR_DOT_BIT = 6;
  localparam int CHAR_COMMA_BIT = 7;

  // Dimming slot timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SLOT_NS = 1000;
  localparam int SLOT_CYC = SLOT_NS / CLK_PERIOD_NS;
  localparam int LUM_STEPS = 31;

  typedef enum logic [1:0] {
    KIND_CHAR = 2'b00,
    KIND_POINTER = 2'b01,
    KIND_DIGITS = 2'b10,
    KIND_LUMA = 2'b11
  } vsbd_kind_t;
endpackage : vsbd_pkg
`default_nettype wire

/* File: logic/vsbd_pin_sync.sv */
// Two-flop synchronisers for the serial pins and clock fall detection
`timescale 1ns/10ps
`default_nettype none
module vsbd_pin_sync (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic sclk_pin, // Serial clock from host
  input wire logic sdata_pin, // Serial data from host
  output logic sclk_fall, // One-cycle pulse on serial clock fall
  output logic sdata_bit // Synchronised data level
);
  logic [1:0] pins;
  logic [1:0] stage1;
  logic [1:0] stage2;
  logic sclk_prev;

  assign pins = {sclk_pin, sdata_pin};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          stage1[g] <= 1'b0;
          stage2[g] <= 1'b0;
        end else begin
          stage1[g] <= pins[g];
          stage2[g] <= stage1[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_prev <= 1'b0;
    end else begin
      sclk_prev <= stage2[1];
    end
  end

  // Both pins see the same delay, so data is read as it stood at the fall
  assign sclk_fall = sclk_prev & ~stage2[1];
  assign sdata_bit = stage2[0];
endmodule : vsbd_pin_sync
`default_nettype wire

/* File: logic/vsbd_byte_fifo.sv */
// Small valid/ready buffer between the shifter and the decoder
`timescale 1ns/10ps
`default_nettype none
module vsbd_byte_fifo #(
  parameter int WIDTH = vsbd_pkg::BYTE_W,
  parameter int DEPTH = vsbd_pkg::FIFO_DEPTH
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic in_valid, // Word offered
  output logic in_ready, // Room for a word
  input wire logic [WIDTH-1:0] in_data, // Word in
  output logic out_valid, // Word available
  input wire logic out_ready, // Consumer takes word
  output logic [WIDTH-1:0] out_data, // Oldest word
  output logic [$clog2(DEPTH):0] level // Words held
);
  localparam int IDX_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [IDX_W-1:0] wr_idx;
  logic [IDX_W-1:0] rd_idx;
  logic push;
  logic pop;

  assign in_ready = (level != DEPTH[$clog2(DEPTH):0]);
  assign out_valid = (level != '0);
  assign out_data = mem[rd_idx];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_idx] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_idx <= '0;
      rd_idx <= '0;
      level <= '0;
    end else begin
      if (push) begin
        wr_idx <= (wr_idx == IDX_W'(DEPTH - 1)) ? '0 : wr_idx + 1'b1;
      end
      if (pop) begin
        rd_idx <= (rd_idx == IDX_W'(DEPTH - 1)) ? '0 : rd_idx + 1'b1;
      end
      if (push && !pop) begin
        level <= level + 1'b1;
      end else if (pop && !push) begin
        level <= level - 1'b1;
      end
    end
  end
endmodule : vsbd_byte_fifo
`default_nettype wire

/* File: logic/vsbd_top.sv */
// Serial byte decoder of a sixteen-position display, with APB status access
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module vsbd_top (
  input wire logic pclk, // System clock, 100 MHz
  input wire logic presetn, // Module reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [vsbd_pkg::ADDR_W-1:0] paddr, // APB byte address
  input wire logic [vsbd_pkg::DATA_W-1:0] pwdata, // APB write data
  output logic [vsbd_pkg::DATA_W-1:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic sclk_pin, // Serial clock from host
  input wire logic sdata_pin, // Serial data from host
  output logic [vsbd_pkg::LUM_W-1:0] brightness_field, // Current brightness
  output logic [vsbd_pkg::DIG_W-1:0] active_digits, // Positions driven, 1 to 16
  output logic display_on // Drivers on in this dimming slot
);
  localparam int LVL_W = $clog2(vsbd_pkg::FIFO_DEPTH) + 1;
  localparam int SLOT_W = $clog2(vsbd_pkg::SLOT_CYC);

  logic sclk_fall;
  logic sdata_bit;
  logic [vsbd_pkg::BYTE_W-1:0] shift_reg;
  logic [vsbd_pkg::CNT_BITS-1:0] bit_cnt;
  logic byte_valid;
  logic [vsbd_pkg::BYTE_W-1:0] byte_data;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [vsbd_pkg::BYTE_W-1:0] fifo_out_data;
  logic [LVL_W-1:0] fifo_level;
  logic take;
  logic hold;
  logic overrun;
  logic [vsbd_pkg::PTR_W-1:0] pointer;
  logic [vsbd_pkg::BYTE_W-1:0] char_buf [vsbd_pkg::POS_N];
  logic [SLOT_W-1:0] slot_cnt;
  logic slot_tick;
  logic [vsbd_pkg::LUM_W-1:0] phase;
  logic access;
  logic mapped;
  logic [vsbd_pkg::CODE_W-1:0] code_in;
  logic [vsbd_pkg::PTR_W-1:0] next_pointer;
  vsbd_pkg::vsbd_kind_t kind_in;

  function automatic vsbd_pkg::vsbd_kind_t classify(input logic [vsbd_pkg::BYTE_W-1:0] b);
    if (!b[7]) begin
      classify = vsbd_pkg::KIND_CHAR;
    end else if (b[7:5] == vsbd_pkg::OP_LUMA) begin
      classify = vsbd_pkg::KIND_LUMA;
    end else if (b[7:4] == vsbd_pkg::OP_DIGITS) begin
      classify = vsbd_pkg::KIND_DIGITS;
    end else if (b[7:4] == vsbd_pkg::OP_POINTER) begin
      classify = vsbd_pkg::KIND_POINTER;
    end else begin
      // Other control prefixes carry no function; treated as a pointer-free no-op below
      classify = vsbd_pkg::KIND_CHAR;
    end
  endfunction : classify

  function automatic logic is_attach(input logic [vsbd_pkg::CODE_W-1:0] c);
    is_attach = (c == vsbd_pkg::CODE_DOT) || (c == vsbd_pkg::CODE_COMMA);
  endfunction : is_attach

  function automatic logic is_unused_ctrl(input logic [vsbd_pkg::BYTE_W-1:0] b);
    is_unused_ctrl = b[7] && (b[7:5] != vsbd_pkg::OP_LUMA) && (b[7:4] != vsbd_pkg::OP_DIGITS)
                     && (b[7:4] != vsbd_pkg::OP_POINTER);
  endfunction : is_unused_ctrl

  vsbd_pin_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .sclk_pin(sclk_pin),
    .sdata_pin(sdata_pin),
    .sclk_fall(sclk_fall),
    .sdata_bit(sdata_bit)
  );

  // Serial shifter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_reg <= 8'h00;
      bit_cnt <= 3'h0;
      byte_valid <= 1'b0;
      byte_data <= 8'h00;
    end else begin
      byte_valid <= 1'b0;
      if (sclk_fall) begin
        shift_reg <= {shift_reg[vsbd_pkg::BYTE_W-2:0], sdata_bit};
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == 3'h7) begin
          byte_valid <= 1'b1;
          byte_data <= {shift_reg[vsbd_pkg::BYTE_W-2:0], sdata_bit};
        end
      end
    end
  end

  // The host cannot be stalled, so a byte that finds the buffer full is dropped and flagged
  vsbd_byte_fifo #(
    .WIDTH(vsbd_pkg::BYTE_W),
    .DEPTH(vsbd_pkg::FIFO_DEPTH)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(byte_valid),
    .in_ready(fifo_in_ready),
    .in_data(byte_data),
    .out_valid(fifo_out_valid),
    .out_ready(!hold),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  assign take = fifo_out_valid & ~hold;
  assign kind_in = classify(fifo_out_data);
  assign code_in = fifo_out_data[vsbd_pkg::CODE_W-1:0];
  assign next_pointer = pointer + 4'h1;

  // Pointer keeps the raw nibble; a character lands at nibble plus one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pointer <= vsbd_pkg::PTR_RST;
    end else if (take) begin
      if (kind_in == vsbd_pkg::KIND_POINTER) begin
        pointer <= fifo_out_data[3:0];
      end else if (kind_in == vsbd_pkg::KIND_CHAR && !fifo_out_data[7] && !is_attach(code_in)) begin
        pointer <= next_pointer;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_digits <= vsbd_pkg::DIGITS_RST;
    end else if (take && kind_in == vsbd_pkg::KIND_DIGITS) begin
      // A nibble of zero stands for all sixteen positions
      active_digits <= (fifo_out_data[3:0] == 4'h0) ? vsbd_pkg::DIGITS_RST
                       : {1'b0, fifo_out_data[3:0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brightness_field <= vsbd_pkg::LUM_RST;
    end else if (take && kind_in == vsbd_pkg::KIND_LUMA) begin
      brightness_field <= fifo_out_data[vsbd_pkg::LUM_W-1:0];
    end
  end

  // Character store; bit 6 of the byte is dropped, leaving 64 codes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < vsbd_pkg::POS_N; i++) begin
        char_buf[i] <= 8'h00;
      end
    end else if (take && !fifo_out_data[7]) begin
      if (is_attach(code_in)) begin
        if (code_in == vsbd_pkg::CODE_DOT) begin
          char_buf[pointer][vsbd_pkg::CHAR_DOT_BIT] <= 1'b1;
        end else begin
          char_buf[pointer][vsbd_pkg::CHAR_COMMA_BIT] <= 1'b1;
        end
      end else begin
        char_buf[next_pointer] <= {2'b00, code_in};
      end
    end
  end

  // Dimming: 31 slots per frame, brightness counts the lit ones
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_cnt <= '0;
      slot_tick <= 1'b0;
    end else begin
      slot_tick <= (slot_cnt == SLOT_W'(vsbd_pkg::SLOT_CYC - 1));
      slot_cnt <= (slot_cnt == SLOT_W'(vsbd_pkg::SLOT_CYC - 1)) ? '0 : slot_cnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 5'h00;
    end else if (slot_tick) begin
      phase <= (phase == 5'(vsbd_pkg::LUM_STEPS - 1)) ? 5'h00 : phase + 5'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      display_on <= 1'b0;
    end else begin
      display_on <= (brightness_field > phase);
    end
  end

  // APB slave, one wait state on every access
  assign access = psel & penable & pready;
  assign mapped = (paddr == vsbd_pkg::REG_CTRL) || (paddr == vsbd_pkg::REG_STATUS)
                  || (paddr == vsbd_pkg::REG_FLAGS) || (paddr[7:6] == vsbd_pkg::CHAR_PAGE && paddr[1:0] == 2'b00);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      prdata <= 32'h0000_0000;
      if (psel && penable && !pready && !pwrite) begin
        if (paddr == vsbd_pkg::REG_CTRL) begin
          prdata[vsbd_pkg::CTRL_HOLD_BIT] <= hold;
        end else if (paddr == vsbd_pkg::REG_STATUS) begin
          prdata[vsbd_pkg::STAT_PTR_LSB +: vsbd_pkg::PTR_W] <= pointer;
          prdata[vsbd_pkg::STAT_DIG_LSB +: vsbd_pkg::DIG_W] <= active_digits;
          prdata[vsbd_pkg::STAT_LUM_LSB +: vsbd_pkg::LUM_W] <= brightness_field;
          prdata[vsbd_pkg::STAT_LVL_LSB +: LVL_W] <= fifo_level;
        end else if (paddr == vsbd_pkg::REG_FLAGS) begin
          prdata[vsbd_pkg::FLAG_OVR_BIT] <= overrun;
        end else if (paddr[7:6] == vsbd_pkg::CHAR_PAGE && paddr[1:0] == 2'b00) begin
          prdata[vsbd_pkg::BYTE_W-1:0] <= char_buf[paddr[5:2]];
        end
      end
    end
  end

  // Hold freezes decoding so software can read a stable buffer; bytes queue meanwhile
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold <= 1'b0;
    end else if (access && pwrite && paddr == vsbd_pkg::REG_CTRL) begin
      hold <= pwdata[vsbd_pkg::CTRL_HOLD_BIT];
    end
  end

  // Overrun is write-one-to-clear; a new overrun in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun <= 1'b0;
    end else if (byte_valid && !fifo_in_ready) begin
      overrun <= 1'b1;
    end else if (access && pwrite && paddr == vsbd_pkg::REG_FLAGS && pwdata[vsbd_pkg::FLAG_OVR_BIT]) begin
      overrun <= 1'b0;
    end
  end

  a_byte_complete: assert property (@(posedge pclk) disable iff (!presetn)
    byte_valid |-> $past(bit_cnt) == 3'h7 && bit_cnt == 3'h0 && $past(sclk_fall))
    else $error("byte released before eight bits");

  a_msb_first: assert property (@(posedge pclk) disable iff (!presetn)
    byte_valid |-> byte_data[7:1] == $past(shift_reg[6:0]) && byte_data[0] == $past(sdata_bit))
    else $error("byte not assembled msb first");

  a_pointer_load: assert property (@(posedge pclk) disable iff (!presetn)
    take && fifo_out_data[7:4] == 4'ha |=> pointer == $past(fifo_out_data[3:0]))
    else $error("pointer byte did not load pointer");

  a_digit_load: assert property (@(posedge pclk) disable iff (!presetn)
    take && fifo_out_data[7:4] == 4'hc |=> active_digits == (($past(fifo_out_data[3:0]) == 4'h0) ? 5'h10
      : {1'b0, $past(fifo_out_data[3:0])}))
    else $error("digit byte did not load count");

  a_luma_load: assert property (@(posedge pclk) disable iff (!presetn)
    take && fifo_out_data[7:5] == 3'h7 |=> brightness_field == $past(fifo_out_data[4:0]))
    else $error("brightness byte did not load field");

  a_char_advance: assert property (@(posedge pclk) disable iff (!presetn)
    take && !fifo_out_data[7] && !is_attach(fifo_out_data[5:0])
      |=> pointer == $past(pointer) + 4'h1 && char_buf[pointer] == {2'b00, $past(fifo_out_data[5:0])})
    else $error("character not stored after advance");

  a_attach_hold: assert property (@(posedge pclk) disable iff (!presetn)
    take && !fifo_out_data[7] && is_attach(fifo_out_data[5:0]) |=> $stable(pointer))
    else $error("dot or comma moved the pointer");

  a_dot_mark: assert property (@(posedge pclk) disable iff (!presetn)
    take && !fifo_out_data[7] && fifo_out_data[5:0] == 6'h2e |=> char_buf[pointer][6])
    else $error("dot not attached to last character");

  a_control_no_store: assert property (@(posedge pclk) disable iff (!presetn)
    take && fifo_out_data[7] && fifo_out_data[7:4] != 4'ha |=> $stable(pointer))
    else $error("control byte treated as character");

  a_unused_ctrl: assert property (@(posedge pclk) disable iff (!presetn)
    take && is_unused_ctrl(fifo_out_data)
      |=> $stable(pointer) && $stable(active_digits) && $stable(brightness_field))
    else $error("unused control byte changed state");

  a_blank_zero: assert property (@(posedge pclk) disable iff (!presetn)
    brightness_field == 5'h00 ##1 brightness_field == 5'h00 |-> !display_on)
    else $error("display lit at zero brightness");

  a_full_on: assert property (@(posedge pclk) disable iff (!presetn)
    brightness_field == 5'h1f |=> display_on)
    else $error("display dark at full brightness");

  a_digits_range: assert property (@(posedge pclk) disable iff (!presetn)
    active_digits != 5'h00 && active_digits <= 5'h10)
    else $error("digit count outside one to sixteen");

  a_reset_state: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> brightness_field == 5'h00 && active_digits == 5'h10 && pointer == 4'hf)
    else $error("wrong state after reset");

  a_reset_count: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> bit_cnt == 3'h0 && !byte_valid)
    else $error("bit count not restarted by reset");

  a_bit_step: assert property (@(posedge pclk) disable iff (!presetn)
    sclk_fall |=> bit_cnt == $past(bit_cnt) + 3'h1)
    else $error("serial fall not counted once");

  a_code_range: assert property (@(posedge pclk) disable iff (!presetn)
    take && !fifo_out_data[7] |=> $stable(brightness_field) && $stable(active_digits))
    else $error("character byte changed a control field");

  a_ready_wait: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pready |=> pready)
    else $error("bus access not answered after one wait state");
endmodule : vsbd_top
`default_nettype wire

/* File: sim/vsbd_host_model.sv */
// Host controller model: shifts bytes into the decoder over the serial link
`timescale 1ns/10ps
`default_nettype none
module vsbd_host_model (
  output logic sclk_pin, // Serial clock to the decoder
  output logic sdata_pin // Serial data to the decoder
);
  initial begin
    sclk_pin = 1'b1;
    sdata_pin = 1'b0;
  end
  // Sends the top n bits of b, MSB first, each taken on a falling clock
  // The clock idles high, so leaving it high between frames gives no false fall
  // Every change lands on a rising system clock edge, so it is made non-blocking
  task automatic send_bits(input logic [7:0] b, input int n, input int half);
    for (int i = 7; i > 7 - n; i--) begin
      sdata_pin <= b[i];
      #(half) sclk_pin <= 1'b0;
      #(half) sclk_pin <= 1'b1;
    end
    // The data line is not held past the frame, so it shows the other level
    sdata_pin <= ~sdata_pin;
  endtask : send_bits
endmodule : vsbd_host_model
`default_nettype wire

/* File: sim/vfd_serial_byte_decoder_bench.sv */
// Self-checking bench of the serial byte decoder
`timescale 1ns/10ps
`default_nettype none
module vfd_serial_byte_decoder_bench;
  typedef struct packed {logic [7:0] b; logic [3:0] p; logic [4:0] d; logic [4:0] l;} vsbd_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sclk_pin;
  logic sdata_pin;
  logic [4:0] brightness_field;
  logic [4:0] active_digits;
  logic display_on;
  logic [31:0] rd;
  logic er;
  int miscompares = 0;
  int checked = 0;
  vsbd_row_t rows [10] = '{'{8'hc6, 4'hf, 5'h06, 5'h00}, '{8'hc0, 4'hf, 5'h10, 5'h00},
    '{8'hf8, 4'hf, 5'h10, 5'h18}, '{8'hff, 4'hf, 5'h10, 5'h1f}, '{8'h41, 4'h0, 5'h10, 5'h1f},
    '{8'ha5, 4'h5, 5'h10, 5'h1f}, '{8'h52, 4'h6, 5'h10, 5'h1f}, '{8'h2e, 4'h6, 5'h10, 5'h1f},
    '{8'h90, 4'h6, 5'h10, 5'h1f}, '{8'he0, 4'h6, 5'h10, 5'h00}};

  always #5 pclk = ~pclk;

  vsbd_host_model host (.sclk_pin(sclk_pin), .sdata_pin(sdata_pin));

  vsbd_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sclk_pin(sclk_pin), .sdata_pin(sdata_pin), .brightness_field(brightness_field),
    .active_digits(active_digits), .display_on(display_on));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Holds the request until pready is seen high at a rising edge; only the watchdog ends a wait
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic status_is(input logic [3:0] p, input logic [4:0] d, input logic [4:0] l, input logic [1:0] v);
    apb(1'b0, vsbd_pkg::REG_STATUS, 32'h0);
    chk(rd & 32'h031f1f0f, {6'h0, v, 3'h0, l, 3'h0, d, 4'h0, p});
  endtask : status_is

  task automatic send(input logic [7:0] b, input int n, input int half);
    host.send_bits(b, n, half);
    repeat (8) @(posedge pclk);
  endtask : send

  task automatic do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset

  task automatic check_reset;
    chk({21'h0, brightness_field, active_digits, display_on}, {21'h0, 5'h00, 5'h10, 1'b0});
    status_is(4'hf, 5'h10, 5'h00, 2'h0);
    $display("test reset done");
  endtask : check_reset

  task automatic give_verdict;
    $display("Counts: checked %0d, miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  initial begin
    #400000;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    miscompares++;
    give_verdict();
  end

  initial begin
    do_reset();
    check_reset();
    // Digit count goes first, as part of start-up
    foreach (rows[i]) begin
      send(rows[i].b, 8, 80);
      status_is(rows[i].p, rows[i].d, rows[i].l, 2'h0);
      chk({27'h0, brightness_field}, {27'h0, rows[i].l});
      chk({27'h0, active_digits}, {27'h0, rows[i].d});
      if (rows[i].l == 5'h1f) chk({31'h0, display_on}, 32'h1);
      if (rows[i].l == 5'h00) chk({31'h0, display_on}, 32'h0);
    end
    apb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h01);
    apb(1'b0, 8'h58, 32'h0);
    chk(rd, 32'h52);
    $display("test rows done");
    apb(1'b0, 8'h0c, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    $display("test unmapped done");
    // Third byte meets a full buffer and is dropped
    apb(1'b1, vsbd_pkg::REG_CTRL, 32'h1);
    apb(1'b0, vsbd_pkg::REG_CTRL, 32'h0);
    chk(rd, 32'h1);
    send(8'ha3, 8, 80);
    send(8'h45, 8, 80);
    send(8'h46, 8, 80);
    status_is(4'h6, 5'h10, 5'h00, 2'h2);
    apb(1'b0, vsbd_pkg::REG_FLAGS, 32'h0);
    chk(rd & 32'h1, 32'h1);
    apb(1'b1, vsbd_pkg::REG_FLAGS, 32'h1);
    apb(1'b0, vsbd_pkg::REG_FLAGS, 32'h0);
    chk(rd & 32'h1, 32'h0);
    apb(1'b1, vsbd_pkg::REG_CTRL, 32'h0);
    repeat (8) @(posedge pclk);
    status_is(4'h4, 5'h10, 5'h00, 2'h0);
    apb(1'b0, 8'h50, 32'h0);
    chk(rd, 32'h05);
    $display("test buffer done");
    send(8'he7, 4, 80);
    chk({27'h0, brightness_field}, 32'h0);
    send(8'h70, 4, 80);
    chk({27'h0, brightness_field}, 32'h7);
    send(8'hc8, 8, 80);
    chk({27'h0, active_digits}, 32'h8);
    $display("test partial done");
    // A half byte left pending when reset strikes must not pair with later bits
    send(8'h00, 4, 80);
    do_reset();
    check_reset();
    send(8'hff, 8, 80);
    chk({27'h0, brightness_field}, 32'h1f);
    $display("test reset restart done");
    give_verdict();
  end
endmodule : vfd_serial_byte_decoder_bench
`default_nettype wire
